// File: fdcrs_pkg.sv
package fdcrs_pkg;
   // ---------------------------------------------------------------
   // modes and rates
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {FDCRS_MODE_REG, FDCRS_MODE_INT, FDCRS_MODE_EXT} fdcrs_mode_t;
   typedef enum logic [2:0] {FDCRS_R150, FDCRS_R250, FDCRS_R300, FDCRS_R500} fdcrs_rate_t;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] FDCRS_A_CTRL = 4'h0;
   localparam logic [3:0] FDCRS_A_DOR = 4'h1;
   localparam logic [3:0] FDCRS_A_CMD = 4'h2;
   localparam logic [3:0] FDCRS_A_STAT = 4'h3;
   localparam logic [3:0] FDCRS_A_IMC = 4'h4;
   localparam logic [3:0] FDCRS_A_FMT = 4'h5;
   localparam logic [3:0] FDCRS_A_MOT = 4'h6;
   localparam logic [3:0] FDCRS_A_SEL = 4'h7;
   localparam int FDCRS_CMD_IMC = 0;
   localparam int FDCRS_CMD_EXT = 1;
   localparam int FDCRS_CMD_FMT = 2;
   localparam int FDCRS_CMD_MOT = 3;
   localparam logic [7:0] FDCRS_CMD_OP_IMC = 8'h01;
   localparam logic [7:0] FDCRS_CMD_OP_EXT = 8'h02;
   localparam logic [7:0] FDCRS_CMD_OP_FMT = 8'h03;
   localparam logic [7:0] FDCRS_CMD_OP_MOT = 8'h04;
   localparam logic [7:0] FDCRS_CMD_OP_SEL = 8'h05;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int FDCRS_CLKA_KHZ = 32000;
   localparam int FDCRS_CLKB_LO_KHZ = 19200;
   localparam int FDCRS_CLKB_HI_KHZ = 38400;
   localparam int FDCRS_SYS_KHZ = 25000;
   // wide enough for the slowest cell doubled in fm
   localparam int FDCRS_DIVW = 9;
   localparam logic [FDCRS_DIVW-1:0] FDCRS_DIV_R600 = 9'h02A;
   localparam logic [FDCRS_DIVW-1:0] FDCRS_DIV_R500 = 9'h032;
   localparam logic [FDCRS_DIVW-1:0] FDCRS_DIV_R300 = 9'h053;
   localparam logic [FDCRS_DIVW-1:0] FDCRS_DIV_R250 = 9'h064;
   localparam logic [FDCRS_DIVW-1:0] FDCRS_DIV_R150 = 9'h0A6;
endpackage : fdcrs_pkg

// File: fdcrs_rate_map.sv
`timescale 1ns/1ps
module fdcrs_rate_map
   import fdcrs_pkg::*;
(
   input wire logic reg_mode_i,
   input wire logic [1:0] code_i,
   input wire logic rate_select_hi_i,
   output fdcrs_rate_t rate_o,
   output logic [1:0] den_low_o
);
   always_comb begin
      rate_o = FDCRS_R250;
      den_low_o = 2'h2;
      if (reg_mode_i) begin
         unique case (code_i)
            2'h0: begin
               rate_o = FDCRS_R500;
               den_low_o = 2'h3;
            end
            2'h1: begin
               if (rate_select_hi_i) begin
                  rate_o = FDCRS_R300;
                  den_low_o = 2'h0;
               end
            end
            2'h2: rate_o = FDCRS_R250;
            2'h3: rate_o = FDCRS_R150;
         endcase
      end else begin
         unique case (code_i)
            2'h0: rate_o = FDCRS_R250;
            2'h1: begin
               rate_o = FDCRS_R500;
               den_low_o = 2'h3;
            end
            2'h2: rate_o = FDCRS_R150;
            2'h3: begin
               rate_o = FDCRS_R300;
               den_low_o = 2'h0;
            end
         endcase
      end
   end
endmodule : fdcrs_rate_map

// File: fdcrs_bitclk.sv
`timescale 1ns/1ps
module fdcrs_bitclk
   import fdcrs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [FDCRS_DIVW-1:0] div_i,
   output logic tick_o
);
   typedef struct packed {
      logic [FDCRS_DIVW-1:0] cnt;
      logic tick;
   } fdcrs_div_st_t;
   fdcrs_div_st_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt >= div_i - FDCRS_DIVW'(1)) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + FDCRS_DIVW'(1);
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tick_o = s_q.tick;
endmodule : fdcrs_bitclk

// File: fdcrs_top.sv
// Operation
// - drive signals active high when polarity_select 0, active low when 1
// - drive outputs idle at inactive level out of reset
// - density outputs follow preset rate at reset, inverted by polarity
// - internal/external codes 00..11 give 250,500,150,300 kb/s
// - register mode ignores rate_select_lo; code 01 depends on rate_select_hi
// - internal mode code from command, external mode from pins
// - fast clock B doubles the 150 and 300 kb/s rates up to 600 kb/s
// - FM recording halves the selected rate
// - tabulated density levels inverted when polarity_select is 0
// - mode pin high gives register mode; else command picks internal/external
// - register mode: drive and motor from output register, precomp from pins
// - internal mode: rate, precomp, drive, format, motor from commands
// - external mode: precomp and format from pins, no vfo mode
// - clock A 32 MHz alone serves 500 and 250 kb/s
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module fdcrs_top
   import fdcrs_pkg::*;
#(
   parameter bit CLKB_FAST = 1'b0,
   parameter bit CLKB_FROM_A = 1'b0
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic polarity_select_i,
   input wire logic mode_select_pin_i,
   input wire logic rate_select_hi_i,
   input wire logic rate_select_lo_i,
   input wire logic precomp_select_0_i,
   input wire logic precomp_select_1_i,
   input wire logic format_select_pin_i,
   input wire logic two_sided_media_i,
   input wire logic dir_req_i,
   input wire logic step_req_i,
   input wire logic side_req_i,
   input wire logic write_gate_req_i,
   input wire logic head_load_req_i,
   input wire logic low_current_req_i,
   input wire logic filter_req_i,
   output logic [3:0] drive_select_outs_o,
   output logic [3:0] motor_enable_outs_o,
   output logic direction_out_o,
   output logic step_out_o,
   output logic side_out_o,
   output logic write_gate_out_o,
   output logic head_load_out_o,
   output logic low_current_out_o,
   output logic filter_out_o,
   output logic density_out_hi_o,
   output logic density_out_lo_o,
   output logic [2:0] precomp_o,
   output logic fm_mode_o,
   output logic clk_src_b_o,
   output logic bit_tick_o,
   output logic two_sided_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      fdcrs_mode_t mode;
      logic [1:0] ctrl_code;
      logic [1:0] imc_code;
      logic [1:0] imc_pc;
      logic imc_fm;
      logic [1:0] dor_sel;
      logic [3:0] dor_mot;
      logic [1:0] cmd_sel;
      logic [3:0] cmd_mot;
      logic [7:0] rdata;
      logic [9:0] drv;
      logic [3:0] ds;
      logic [3:0] em;
      logic [1:0] den;
      logic live;
   } fdcrs_st_t;
   fdcrs_st_t s_q, s_d;

   logic [1:0] code;
   fdcrs_rate_t rate;
   logic [1:0] den_low;
   logic fm;
   logic use_b;
   logic [FDCRS_DIVW-1:0] div;
   logic [9:0] drv_act;
   logic [3:0] ds_act;
   logic [3:0] em_act;
   logic [1:0] sel;

   // ---------------------------------------------------------------
   // rate selection
   // ---------------------------------------------------------------
   always_comb begin
      unique case (s_q.mode)
         FDCRS_MODE_REG: code = s_q.ctrl_code;
         FDCRS_MODE_INT: code = s_q.imc_code;
         FDCRS_MODE_EXT: code = {rate_select_hi_i, rate_select_lo_i};
         default: code = s_q.ctrl_code;
      endcase
   end

   fdcrs_rate_map u_map (
      .reg_mode_i(s_q.mode == FDCRS_MODE_REG),
      .code_i(code),
      .rate_select_hi_i(rate_select_hi_i),
      .rate_o(rate),
      .den_low_o(den_low)
   );

   // format: command in internal mode, pin otherwise
   assign fm = (s_q.mode == FDCRS_MODE_INT) ? s_q.imc_fm : format_select_pin_i;

   // clock A for 500/250; crystal-less builds feed A into B so B math uses A
   assign use_b = !CLKB_FROM_A && (rate == FDCRS_R150 || rate == FDCRS_R300);

   // divider per bit cell at 25 MHz system clock, scaled from source/rate
   always_comb begin
      unique case (rate)
         FDCRS_R500: div = FDCRS_DIV_R500;
         FDCRS_R250: div = FDCRS_DIV_R250;
         FDCRS_R300: div = CLKB_FAST ? FDCRS_DIV_R600 : FDCRS_DIV_R300;
         FDCRS_R150: div = CLKB_FAST ? FDCRS_DIV_R300 : FDCRS_DIV_R150;
         default: div = FDCRS_DIV_R250;
      endcase
      if (fm) begin
         div = {div[FDCRS_DIVW-2:0], 1'b0};
      end
   end

   fdcrs_bitclk u_div (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .div_i(div),
      .tick_o(bit_tick_o)
   );

   // ---------------------------------------------------------------
   // drive interface
   // ---------------------------------------------------------------
   assign drv_act = {filter_req_i, low_current_req_i, head_load_req_i, write_gate_req_i,
                     side_req_i, step_req_i, dir_req_i, 3'h0};
   assign sel = (s_q.mode == FDCRS_MODE_REG) ? s_q.dor_sel : s_q.cmd_sel;
   always_comb begin
      ds_act = '0;
      ds_act[sel] = 1'b1;
      em_act = (s_q.mode == FDCRS_MODE_REG) ? s_q.dor_mot : s_q.cmd_mot;
   end

   // ---------------------------------------------------------------
   // registers and commands
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rdata = '0;
      if (mode_select_pin_i) begin
         s_d.mode = FDCRS_MODE_REG;
      end else if (s_q.mode == FDCRS_MODE_REG) begin
         s_d.mode = FDCRS_MODE_INT;
      end
      if (wr_i) begin
         unique case (addr_i)
            FDCRS_A_CTRL: s_d.ctrl_code = wdata_i[1:0];
            FDCRS_A_DOR: begin
               s_d.dor_sel = wdata_i[1:0];
               s_d.dor_mot = wdata_i[7:4];
            end
            FDCRS_A_CMD: begin
               if (!mode_select_pin_i) begin
                  unique case (wdata_i)
                     FDCRS_CMD_OP_IMC: s_d.mode = FDCRS_MODE_INT;
                     FDCRS_CMD_OP_EXT: s_d.mode = FDCRS_MODE_EXT;
                     default: s_d.mode = s_d.mode;
                  endcase
               end
            end
            FDCRS_A_IMC: begin
               s_d.imc_code = wdata_i[1:0];
               s_d.imc_pc = wdata_i[3:2];
            end
            FDCRS_A_FMT: s_d.imc_fm = wdata_i[0];
            FDCRS_A_MOT: s_d.cmd_mot = wdata_i[3:0];
            FDCRS_A_SEL: s_d.cmd_sel = wdata_i[1:0];
            default: s_d.mode = s_d.mode;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            FDCRS_A_CTRL: s_d.rdata = {6'h00, s_q.ctrl_code};
            FDCRS_A_DOR: s_d.rdata = {s_q.dor_mot, 2'h0, s_q.dor_sel};
            FDCRS_A_STAT: s_d.rdata = {1'b0, fm, 1'b0, rate, s_q.mode};
            default: s_d.rdata = '0;
         endcase
      end
      s_d.drv = drv_act ^ {10{polarity_select_i}};
      s_d.ds = ds_act ^ {4{polarity_select_i}};
      s_d.em = em_act ^ {4{polarity_select_i}};
      s_d.den = polarity_select_i ? den_low : ~den_low;
      s_d.live = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // cleared registers hold no polarity, so strap level until first edge after reset
   assign direction_out_o = s_q.live ? s_q.drv[3] : polarity_select_i;
   assign step_out_o = s_q.live ? s_q.drv[4] : polarity_select_i;
   assign side_out_o = s_q.live ? s_q.drv[5] : polarity_select_i;
   assign write_gate_out_o = s_q.live ? s_q.drv[6] : polarity_select_i;
   assign head_load_out_o = s_q.live ? s_q.drv[7] : polarity_select_i;
   assign low_current_out_o = s_q.live ? s_q.drv[8] : polarity_select_i;
   assign filter_out_o = s_q.live ? s_q.drv[9] : polarity_select_i;
   assign drive_select_outs_o = s_q.live ? s_q.ds : {4{polarity_select_i}};
   assign motor_enable_outs_o = s_q.live ? s_q.em : {4{polarity_select_i}};
   assign density_out_hi_o = s_q.live ? s_q.den[1] : (den_low[1] ~^ polarity_select_i);
   assign density_out_lo_o = s_q.live ? s_q.den[0] : (den_low[0] ~^ polarity_select_i);
   assign precomp_o = (s_q.mode == FDCRS_MODE_INT) ? {1'b0, s_q.imc_pc}
                      : {rate_select_hi_i, precomp_select_1_i, precomp_select_0_i};
   assign fm_mode_o = fm;
   assign clk_src_b_o = use_b;
   assign two_sided_o = two_sided_media_i ^ polarity_select_i;
   assign rdata_o = s_q.rdata;
endmodule : fdcrs_top

// File: fdcrs_sva.sv
`timescale 1ns/1ps
// ------
// port checker
// ------
module fdcrs_sva
   import fdcrs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic polarity_select_i,
   input wire logic mode_select_pin_i,
   input wire logic rate_select_hi_i,
   input wire logic rate_select_lo_i,
   input wire logic format_select_pin_i,
   input wire logic two_sided_media_i,
   input wire logic step_req_i,
   input wire logic [3:0] motor_enable_outs_o,
   input wire logic step_out_o,
   input wire logic density_out_hi_o,
   input wire logic density_out_lo_o,
   input wire logic fm_mode_o,
   input wire logic two_sided_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // no write in the wait, else the motor field moves again
   sequence s_dor_write;
      wr_i && addr_i == FDCRS_A_DOR && mode_select_pin_i ##1
         (!wr_i && $stable(polarity_select_i))[*2];
   endsequence
   sequence s_pol_flip;
      $changed(polarity_select_i) && !wr_i &&
         $stable({mode_select_pin_i, rate_select_hi_i, rate_select_lo_i});
   endsequence
   a_rdata_idle:
      assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   a_unmapped_read:
      assert property (rd_i && addr_i[3] |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_step_polarity:
      assert property (step_out_o == ($past(step_req_i) ^ $past(polarity_select_i)))
      else $error("step level wrong");
   a_den_invert:
      assert property (s_pol_flip |=> density_out_hi_o == !$past(density_out_hi_o) &&
         density_out_lo_o == !$past(density_out_lo_o))
      else $error("density not inverted");
   a_lo_ignored:
      assert property (mode_select_pin_i && $past(mode_select_pin_i) && !wr_i &&
         $changed(rate_select_lo_i) && $stable(rate_select_hi_i) &&
         $stable(polarity_select_i) |=> $stable(density_out_hi_o) && $stable(density_out_lo_o))
      else $error("low rate pin used");
   a_fmt_pin:
      assert property (mode_select_pin_i && $past(mode_select_pin_i) |->
         fm_mode_o == format_select_pin_i)
      else $error("format not from pin");
   a_dor_motor:
      assert property (s_dor_write |=>
         motor_enable_outs_o == ($past(wdata_i[7:4], 3) ^ {4{polarity_select_i}}))
      else $error("motor outputs wrong");
   a_two_sided:
      assert property ($stable(two_sided_media_i) && $stable(polarity_select_i) |->
         two_sided_o == (two_sided_media_i ^ polarity_select_i))
      else $error("media flag wrong");
endmodule : fdcrs_sva

bind fdcrs_top fdcrs_sva i_sva (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .polarity_select_i, .mode_select_pin_i, .rate_select_hi_i, .rate_select_lo_i,
   .format_select_pin_i, .two_sided_media_i, .step_req_i, .motor_enable_outs_o,
   .step_out_o, .density_out_hi_o, .density_out_lo_o, .fm_mode_o, .two_sided_o);

// File: fdcrs_drive_model.sv
`timescale 1ns/1ps
// ------
// drive media sense
// ------
module fdcrs_drive_model (
   input wire logic polarity_select_i,
   input wire logic two_sided_i,
   output logic two_sided_media_o
);
   // level held while media sits in the drive
   assign two_sided_media_o = two_sided_i ^ polarity_select_i;
endmodule : fdcrs_drive_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top
   import fdcrs_pkg::*;
;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, media_two = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, st;
   logic polarity_select_i = 1'b0, mode_select_pin_i = 1'b1, rate_select_hi_i = 1'b0;
   logic rate_select_lo_i = 1'b0, precomp_select_0_i = 1'b0, precomp_select_1_i = 1'b0;
   logic format_select_pin_i = 1'b0, two_sided_media_i;
   logic dir_req_i, step_req_i, side_req_i, write_gate_req_i;
   logic head_load_req_i, low_current_req_i, filter_req_i;
   logic [3:0] drive_select_outs_o, motor_enable_outs_o;
   logic direction_out_o, step_out_o, side_out_o, write_gate_out_o, head_load_out_o;
   logic low_current_out_o, filter_out_o, density_out_hi_o, density_out_lo_o;
   logic [2:0] precomp_o;
   logic fm_mode_o, clk_src_b_o, bit_tick_o, two_sided_o;
   logic [6:0] req_v = 7'h00;
   logic [6:0] drv_v;
   int err_total = 0;
   int cmp_count = 0;
   assign {dir_req_i, step_req_i, side_req_i, write_gate_req_i, head_load_req_i,
      low_current_req_i, filter_req_i} = req_v;
   assign drv_v = {direction_out_o, step_out_o, side_out_o, write_gate_out_o,
      head_load_out_o, low_current_out_o, filter_out_o};
   fdcrs_top i_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .polarity_select_i, .mode_select_pin_i, .rate_select_hi_i, .rate_select_lo_i,
      .precomp_select_0_i, .precomp_select_1_i, .format_select_pin_i, .two_sided_media_i,
      .dir_req_i, .step_req_i, .side_req_i, .write_gate_req_i, .head_load_req_i,
      .low_current_req_i, .filter_req_i, .drive_select_outs_o, .motor_enable_outs_o,
      .direction_out_o, .step_out_o, .side_out_o, .write_gate_out_o, .head_load_out_o,
      .low_current_out_o, .filter_out_o, .density_out_hi_o, .density_out_lo_o,
      .precomp_o, .fm_mode_o, .clk_src_b_o, .bit_tick_o, .two_sided_o);
   fdcrs_drive_model i_drive (.polarity_select_i, .two_sided_i(media_two),
      .two_sided_media_o(two_sided_media_i));
   always #20 clk_i = ~clk_i;
   // ------
   // helpers
   // ------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // gap cycle after each strobe keeps one assignment per step
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      d = rdata_o;
   endtask : bus_rd
   function automatic logic [4:0] ext_tab(input logic [1:0] c);
      case (c)
         2'h0: return {2'h2, FDCRS_R250};
         2'h1: return {2'h3, FDCRS_R500};
         2'h2: return {2'h2, FDCRS_R150};
         default: return {2'h0, FDCRS_R300};
      endcase
   endfunction : ext_tab
   // one bit cell in system cycles, from one tick to the next
   task automatic chk_tick(input logic [2:0] r, input logic f);
      int n;
      int kbps;
      n = 0;
      case (r)
         FDCRS_R150: kbps = 150;
         FDCRS_R250: kbps = 250;
         FDCRS_R300: kbps = 300;
         default: kbps = 500;
      endcase
      while (bit_tick_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (bit_tick_o !== 1'b1 && n < 700);
      chk("bit_cell", 16'(n), 16'(FDCRS_SYS_KHZ / kbps * (f ? 2 : 1)));
   endtask : chk_tick
   task automatic chk_rate(input logic [4:0] e, input logic [1:0] m, input logic f);
      repeat (3) @(posedge clk_i);
      bus_rd(FDCRS_A_STAT, st);
      chk("density", {density_out_hi_o, density_out_lo_o}, e[4:3] ^ {2{!polarity_select_i}});
      chk("rate", st[4:2], e[2:0]);
      chk("mode", st[1:0], m);
      chk("clock_b", clk_src_b_o, e[2:0] == FDCRS_R150 || e[2:0] == FDCRS_R300);
      chk_tick(e[2:0], f);
   endtask : chk_rate
   // ------
   // scenarios
   // ------
   task automatic t_reset(input logic p);
      rst_n_i <= 1'b0;
      polarity_select_i <= p;
      repeat (16) @(posedge clk_i);
      chk("idle", {drv_v, drive_select_outs_o, motor_enable_outs_o}, {15{p}});
      chk("reset_density", {density_out_hi_o, density_out_lo_o}, {2{p}});
      rst_n_i <= 1'b1;
      @(posedge clk_i);
   endtask : t_reset
   task automatic t_reg(input logic p);
      logic [4:0] e;
      polarity_select_i <= p;
      repeat (2) @(posedge clk_i);
      for (int c = 0; c < 8; c++) begin
         rate_select_hi_i <= c[2];
         format_select_pin_i <= c[0];
         bus_wr(FDCRS_A_CTRL, 8'(c[1:0]));
         rate_select_lo_i <= !rate_select_lo_i;
         e = (c[1:0] == 2'h0) ? {2'h3, FDCRS_R500} : (c[1:0] == 2'h3) ? {2'h2, FDCRS_R150} :
            (c[1:0] == 2'h1 && c[2]) ? {2'h0, FDCRS_R300} : {2'h2, FDCRS_R250};
         chk_rate(e, FDCRS_MODE_REG, c[0]);
         chk("fm", fm_mode_o, c[0]);
      end
      bus_wr(FDCRS_A_DOR, 8'hA1);
      req_v <= 7'h55;
      media_two <= !p;
      precomp_select_0_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("motors", motor_enable_outs_o, 4'hA ^ {4{p}});
      chk("drive_select", drive_select_outs_o, 4'h2 ^ {4{p}});
      chk("precomp", precomp_o, 3'h5);
      chk("drive", drv_v, 7'h55 ^ {7{p}});
      chk("two_sided", two_sided_o, !p);
      bus_rd(4'hF, st);
      chk("unmapped", st, 8'h00);
   endtask : t_reg
   task automatic t_ext();
      mode_select_pin_i <= 1'b0;
      format_select_pin_i <= 1'b1;
      precomp_select_1_i <= 1'b1;
      precomp_select_0_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      bus_wr(FDCRS_A_CMD, FDCRS_CMD_OP_EXT);
      for (int c = 0; c < 4; c++) begin
         {rate_select_hi_i, rate_select_lo_i} <= 2'(c);
         chk_rate(ext_tab(2'(c)), FDCRS_MODE_EXT, 1'b1);
         chk("precomp", precomp_o, {c[1], 2'h2});
      end
      chk("fm", fm_mode_o, 1'b1);
   endtask : t_ext
   task automatic t_int();
      bus_wr(FDCRS_A_CMD, FDCRS_CMD_OP_IMC);
      bus_wr(FDCRS_A_FMT, 8'h00);
      for (int c = 0; c < 4; c++) begin
         bus_wr(FDCRS_A_IMC, 8'(c) | 8'h0C);
         {rate_select_hi_i, rate_select_lo_i} <= ~2'(c);
         chk_rate(ext_tab(2'(c)), FDCRS_MODE_INT, 1'b0);
         chk("precomp", precomp_o, 3'h3);
      end
      chk("fm", fm_mode_o, 1'b0);
      bus_wr(FDCRS_A_MOT, 8'h05);
      bus_wr(FDCRS_A_SEL, 8'h03);
      @(posedge clk_i);
      chk("cmd_motors", motor_enable_outs_o, 4'h5 ^ {4{polarity_select_i}});
      chk("cmd_select", drive_select_outs_o, 4'h8 ^ {4{polarity_select_i}});
   endtask : t_int
   task automatic tally_and_finish();
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      t_reset(1'b0);
      t_reset(1'b1);
      t_reg(1'b0);
      t_reg(1'b1);
      t_ext();
      t_int();
      tally_and_finish();
   end
   initial begin
      // 24 cell measurements of at most 1100 cycles each, plus bus traffic
      repeat (40000) @(posedge clk_i);
      err_total++;
      tally_and_finish();
   end
endmodule : tb_top
